//--- hdl/c3wtd_defs.vh
// constants for the channel 3 window threshold and debounce block
// assumes an 8-bit register port and a 125 MHz mclk
`ifndef C3WTD_DEFS_VH
`define C3WTD_DEFS_VH

// register port widths
`define C3WTD_ADDR_W 8
`define C3WTD_DATA_W 8

// register byte offsets
`define C3WTD_OFF_HF_UV   8'h40
`define C3WTD_OFF_HF_OV   8'h41
`define C3WTD_OFF_LF_UV   8'h42
`define C3WTD_OFF_LF_OV   8'h43
`define C3WTD_OFF_DEB     8'h44
`define C3WTD_OFF_STATUS  8'h48
`define C3WTD_OFF_CLEAR   8'h49
`define C3WTD_OFF_ENABLE  8'h4A
`define C3WTD_OFF_STATE   8'h4B

// debounce register fields
`define C3WTD_OV_DEB_MSB 7
`define C3WTD_OV_DEB_LSB 4
`define C3WTD_UV_DEB_MSB 3
`define C3WTD_UV_DEB_LSB 0

// event bits of status, clear and enable
`define C3WTD_EV_UV  0
`define C3WTD_EV_OV  1
`define C3WTD_EV_CFG 2
`define C3WTD_EV_W   3

// reset values
`define C3WTD_LIMIT_RST 8'h00
`define C3WTD_DEB_RST   8'h00
`define C3WTD_EV_RST    3'h0

// limit scaling, millivolts
`define C3WTD_MV_W        13
`define C3WTD_MV_1X_BASE  13'h0C8
`define C3WTD_MV_1X_STEP  13'h005
`define C3WTD_MV_4X_BASE  13'h320
`define C3WTD_MV_4X_STEP  13'h014

// debounce timing
`define C3WTD_CLK_NS          8
`define C3WTD_DEB_BASE_NS     100
`define C3WTD_DEB_MAX_CODE    4'hA
`define C3WTD_DEB_LONGEST_NS  102400
`define C3WTD_DEB_LONGEST_CYC ((`C3WTD_DEB_LONGEST_NS + `C3WTD_CLK_NS - 1) / `C3WTD_CLK_NS)
`define C3WTD_DEB_CNT_W       14

`endif

//--- hdl/c3wtd_thresh_decode.v
// converts one 8-bit limit code into millivolts under the range scaling
// assumes scale_4x comes from logic on mclk
`include "c3wtd_defs.vh"

module c3wtd_thresh_decode (
  // clock and reset
  input  wire                   mclk,
  input  wire                   nrst,
  // code in
  input  wire                   scale_4x,
  input  wire [7:0]             code,
  // decoded limit
  output reg  [`C3WTD_MV_W-1:0] mv
);

  wire [`C3WTD_MV_W-1:0] code_wide;
  wire [`C3WTD_MV_W-1:0] mv_1x;
  wire [`C3WTD_MV_W-1:0] mv_4x;

  assign code_wide = {5'h00, code};
  // full scale stays below 8191, so 13 bits never wrap
  assign mv_1x = `C3WTD_MV_1X_BASE + code_wide * `C3WTD_MV_1X_STEP;
  assign mv_4x = `C3WTD_MV_4X_BASE + code_wide * `C3WTD_MV_4X_STEP;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mv <= {`C3WTD_MV_W{1'b0}};
    end else begin
      mv <= scale_4x ? mv_4x : mv_1x;
    end
  end

endmodule

//--- hdl/c3wtd_debounce.v
// qualifies one synchronised comparator output with a coded stable time
// assumes raw is already on mclk; the code may change at any time
`include "c3wtd_defs.vh"

module c3wtd_debounce #(
  parameter [31:0] LONGEST_CYCLES = `C3WTD_DEB_LONGEST_CYC,
  parameter        CNT_W          = `C3WTD_DEB_CNT_W
) (
  // clock and reset
  input  wire       mclk,
  input  wire       nrst,
  // qualification
  input  wire       enable,
  input  wire       raw,
  input  wire [3:0] code,
  // result
  output reg        fault
);

  reg  [CNT_W-1:0] count;
  wire [3:0]       eff_code;
  wire [3:0]       shift;
  wire [31:0]      round_up;
  wire [31:0]      target;
  wire [31:0]      count_wide;

  // codes past the top all select the longest time
  assign eff_code   = (code > `C3WTD_DEB_MAX_CODE) ? `C3WTD_DEB_MAX_CODE : code;
  assign shift      = `C3WTD_DEB_MAX_CODE - eff_code;
  // halving from the longest time, rounded up so no interval comes out short
  assign round_up   = (32'h1 << shift) - 32'h1;
  assign target     = (LONGEST_CYCLES + round_up) >> shift;
  assign count_wide = {{(32-CNT_W){1'b0}}, count};

  // release is immediate; only assertion is held off
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count <= {CNT_W{1'b0}};
      fault <= 1'b0;
    end else if (!enable || !raw) begin
      count <= {CNT_W{1'b0}};
      fault <= 1'b0;
    end else if (!fault) begin
      if (count_wide + 32'h1 >= target) begin
        fault <= 1'b1;
      end else begin
        count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

//--- hdl/c3wtd_top.v
// channel 3 limit registers, limit decoding and high-frequency fault debounce
// assumes comparator outputs arrive unsynchronised from pins and the
// range scaling bit comes from another register on mclk
//
// Chosen here: strobed register access.
`include "c3wtd_defs.vh"

// Notes on behaviour
// - The high-frequency undervoltage limit is an 8-bit register filling bits 7 to 0.
// - The high-frequency overvoltage limit is an 8-bit register filling the byte.
// - The low-frequency undervoltage limit is an 8-bit register filling the byte.
// - The low-frequency overvoltage limit is an 8-bit register filling the byte.
// - All four limit codes are decoded under the external range scaling setting.
// - At one times scaling a code means 200 mV plus 5 mV per step, up to 1475 mV.
// - At four times scaling a code means 800 mV plus 20 mV per step, up to 5900 mV.
// - A high-frequency fault asserts only after the comparator stays set for the interval.
// - The overvoltage debounce code sits in bits 7 to 4 of the debounce register.
// - The undervoltage debounce code sits in bits 3 to 0 of the debounce register.
// - A debounce code means 0.1 us doubled per step; 1010b and above mean 102.4 us.
module c3wtd_top #(
  parameter [31:0] DEB_LONGEST_CYCLES = `C3WTD_DEB_LONGEST_CYC
) (
  // clock and reset
  input  wire                   mclk,
  input  wire                   nrst,
  // register port
  input  wire [7:0]             reg_addr,
  input  wire [7:0]             reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [7:0]             reg_rdata,
  // comparator outputs from the rail
  input  wire                   hf_undervolt_raw,
  input  wire                   hf_overvolt_raw,
  // range scaling, high for four times
  input  wire                   range_scaling_setting,
  // limit codes
  output wire [7:0]             ch3_hf_undervolt_limit,
  output wire [7:0]             ch3_hf_overvolt_limit,
  output wire [7:0]             ch3_lf_undervolt_limit,
  output wire [7:0]             ch3_lf_overvolt_limit,
  // decoded limits in millivolts
  output wire [`C3WTD_MV_W-1:0] hf_undervolt_mv,
  output wire [`C3WTD_MV_W-1:0] hf_overvolt_mv,
  output wire [`C3WTD_MV_W-1:0] lf_undervolt_mv,
  output wire [`C3WTD_MV_W-1:0] lf_overvolt_mv,
  // debounce selection
  output wire [3:0]             overvolt_debounce_code,
  output wire [3:0]             undervolt_debounce_code,
  // channel state
  output reg                    channel_configured,
  output wire                   hf_undervolt_fault,
  output wire                   hf_overvolt_fault,
  output reg                    irq
);

  // limit registers in offset order: hf uv, hf ov, lf uv, lf ov
  wire [31:0]               limit_all;
  wire [4*`C3WTD_MV_W-1:0]  mv_all;
  wire [3:0]                limit_written;
  reg  [7:0]                ch3_hf_debounce_select;
  reg                       deb_written;

  // synchronisers for the comparator pins
  reg                       uv_meta;
  reg                       uv_sync;
  reg                       ov_meta;
  reg                       ov_sync;

  // event logic
  reg  [`C3WTD_EV_W-1:0]    ev_status;
  reg  [`C3WTD_EV_W-1:0]    ev_enable;
  reg                       uv_fault_prev;
  reg                       ov_fault_prev;
  reg                       cfg_prev;
  reg  [`C3WTD_EV_W-1:0]    ev_set;
  reg  [`C3WTD_EV_W-1:0]    ev_clr;
  reg  [`C3WTD_EV_W-1:0]    next_status;
  reg  [`C3WTD_EV_W-1:0]    next_enable;
  reg  [7:0]                next_rdata;
  wire                      next_configured;

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_limit
      reg  [7:0] limit;
      reg        written;
      wire [7:0] offset;

      // widened first so the genvar is never part-selected
      localparam [31:0] OFFSET_WIDE = `C3WTD_OFF_HF_UV + i;
      assign offset = OFFSET_WIDE[7:0];

      // each limit is a plain full-byte register
      always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          limit   <= `C3WTD_LIMIT_RST;
          written <= 1'b0;
        end else if (reg_wr && reg_addr == offset) begin
          limit   <= reg_wdata;
          written <= 1'b1;
        end
      end

      assign limit_all[8*i+7:8*i] = limit;
      assign limit_written[i]     = written;

      c3wtd_thresh_decode u_decode (
        .mclk     (mclk),
        .nrst     (nrst),
        .scale_4x (range_scaling_setting),
        .code     (limit),
        .mv       (mv_all[`C3WTD_MV_W*i+`C3WTD_MV_W-1:`C3WTD_MV_W*i])
      );
    end
  endgenerate

  assign ch3_hf_undervolt_limit = limit_all[7:0];
  assign ch3_hf_overvolt_limit  = limit_all[15:8];
  assign ch3_lf_undervolt_limit = limit_all[23:16];
  assign ch3_lf_overvolt_limit  = limit_all[31:24];
  assign hf_undervolt_mv        = mv_all[`C3WTD_MV_W-1:0];
  assign hf_overvolt_mv         = mv_all[2*`C3WTD_MV_W-1:`C3WTD_MV_W];
  assign lf_undervolt_mv        = mv_all[3*`C3WTD_MV_W-1:2*`C3WTD_MV_W];
  assign lf_overvolt_mv         = mv_all[4*`C3WTD_MV_W-1:3*`C3WTD_MV_W];

  // debounce register
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ch3_hf_debounce_select <= `C3WTD_DEB_RST;
      deb_written            <= 1'b0;
    end else if (reg_wr && reg_addr == `C3WTD_OFF_DEB) begin
      ch3_hf_debounce_select <= reg_wdata;
      deb_written            <= 1'b1;
    end
  end

  assign overvolt_debounce_code  =
    ch3_hf_debounce_select[`C3WTD_OV_DEB_MSB:`C3WTD_OV_DEB_LSB];
  assign undervolt_debounce_code =
    ch3_hf_debounce_select[`C3WTD_UV_DEB_MSB:`C3WTD_UV_DEB_LSB];

  // the limits reset to code 00h until written, so a fault on stale codes would be noise
  assign next_configured = (&limit_written) & deb_written;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      channel_configured <= 1'b0;
    end else begin
      channel_configured <= next_configured;
    end
  end

  // two flops before anything reads the pins
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      uv_meta <= 1'b0;
      uv_sync <= 1'b0;
      ov_meta <= 1'b0;
      ov_sync <= 1'b0;
    end else begin
      uv_meta <= hf_undervolt_raw;
      uv_sync <= uv_meta;
      ov_meta <= hf_overvolt_raw;
      ov_sync <= ov_meta;
    end
  end

  c3wtd_debounce #(
    .LONGEST_CYCLES (DEB_LONGEST_CYCLES),
    .CNT_W          (`C3WTD_DEB_CNT_W)
  ) u_uv_debounce (
    .mclk   (mclk),
    .nrst   (nrst),
    .enable (channel_configured),
    .raw    (uv_sync),
    .code   (undervolt_debounce_code),
    .fault  (hf_undervolt_fault)
  );

  c3wtd_debounce #(
    .LONGEST_CYCLES (DEB_LONGEST_CYCLES),
    .CNT_W          (`C3WTD_DEB_CNT_W)
  ) u_ov_debounce (
    .mclk   (mclk),
    .nrst   (nrst),
    .enable (channel_configured),
    .raw    (ov_sync),
    .code   (overvolt_debounce_code),
    .fault  (hf_overvolt_fault)
  );

  // sticky events, a set in the same cycle as its clear wins
  always @* begin
    ev_set                = {`C3WTD_EV_W{1'b0}};
    ev_set[`C3WTD_EV_UV]  = hf_undervolt_fault & ~uv_fault_prev;
    ev_set[`C3WTD_EV_OV]  = hf_overvolt_fault & ~ov_fault_prev;
    ev_set[`C3WTD_EV_CFG] = channel_configured & ~cfg_prev;
    ev_clr                = {`C3WTD_EV_W{1'b0}};
    if (reg_wr && reg_addr == `C3WTD_OFF_CLEAR) begin
      ev_clr = reg_wdata[`C3WTD_EV_W-1:0];
    end
    next_status = (ev_status & ~ev_clr) | ev_set;
    next_enable = ev_enable;
    if (reg_wr && reg_addr == `C3WTD_OFF_ENABLE) begin
      next_enable = reg_wdata[`C3WTD_EV_W-1:0];
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ev_status     <= `C3WTD_EV_RST;
      ev_enable     <= `C3WTD_EV_RST;
      uv_fault_prev <= 1'b0;
      ov_fault_prev <= 1'b0;
      cfg_prev      <= 1'b0;
      irq           <= 1'b0;
    end else begin
      ev_status     <= next_status;
      ev_enable     <= next_enable;
      uv_fault_prev <= hf_undervolt_fault;
      ov_fault_prev <= hf_overvolt_fault;
      cfg_prev      <= channel_configured;
      irq           <= |(next_status & next_enable);
    end
  end

  // read mux; unmapped offsets and the clear register read as zero
  always @* begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `C3WTD_OFF_HF_UV:  next_rdata = limit_all[7:0];
        `C3WTD_OFF_HF_OV:  next_rdata = limit_all[15:8];
        `C3WTD_OFF_LF_UV:  next_rdata = limit_all[23:16];
        `C3WTD_OFF_LF_OV:  next_rdata = limit_all[31:24];
        `C3WTD_OFF_DEB:    next_rdata = ch3_hf_debounce_select;
        `C3WTD_OFF_STATUS: next_rdata = {5'h00, ev_status};
        `C3WTD_OFF_ENABLE: next_rdata = {5'h00, ev_enable};
        `C3WTD_OFF_STATE:  next_rdata = {5'h00, channel_configured,
                                         hf_overvolt_fault, hf_undervolt_fault};
        default:           next_rdata = 8'h00;
      endcase
    end
  end

  // data stands for exactly the cycle after the strobe
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

//--- verification/c3wtd_rail_model.sv
// comparator pair watching the monitored rail against the decoded hf limits
// assumes the bench moves rail_mv just after a clock edge
module c3wtd_rail_model (
  // rail and limits
  input  wire [12:0] rail_mv,
  input  wire [12:0] uv_mv,
  input  wire [12:0] ov_mv,
  // comparator outputs
  output wire        uv_raw,
  output wire        ov_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  // no hysteresis: the bench never parks the rail on a limit
  assign uv_raw = rail_mv < uv_mv;
  assign ov_raw = rail_mv > ov_mv;
endmodule

//--- verification/c3wtd_top_sva.sv
// checker for the channel 3 limit and debounce block
// assumes one mclk domain and the async active-low nrst
module c3wtd_sva #(
  parameter [31:0] DEB_LONGEST_CYCLES = 32'd12800
) (
  // clock and reset
  input wire        mclk,
  input wire        nrst,
  // register port
  input wire [7:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  // comparators and scaling
  input wire        hf_undervolt_raw,
  input wire        hf_overvolt_raw,
  input wire        range_scaling_setting,
  // observed state
  input wire [7:0]  ch3_hf_undervolt_limit,
  input wire [7:0]  ch3_lf_overvolt_limit,
  input wire [12:0] hf_undervolt_mv,
  input wire [12:0] lf_overvolt_mv,
  input wire [3:0]  overvolt_debounce_code,
  input wire [3:0]  undervolt_debounce_code,
  input wire        channel_configured,
  input wire        hf_undervolt_fault,
  input wire        hf_overvolt_fault
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  read_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  hf_uv_write_a: assert property (reg_wr && reg_addr == 8'h40 |=>
    ch3_hf_undervolt_limit == $past(reg_wdata)) else $error("hf uv limit not written");
  lf_ov_write_a: assert property (reg_wr && reg_addr == 8'h43 |=>
    ch3_lf_overvolt_limit == $past(reg_wdata)) else $error("lf ov limit not written");
  deb_fields_a: assert property (reg_wr && reg_addr == 8'h44 |=>
    {overvolt_debounce_code, undervolt_debounce_code} == $past(reg_wdata))
    else $error("debounce fields misplaced");
  hf_uv_scale_a: assert property (1'b1 |=> hf_undervolt_mv ==
    ($past(range_scaling_setting) ? 13'h320 + 13'h014 * $past(ch3_hf_undervolt_limit)
                                  : 13'h0C8 + 13'h005 * $past(ch3_hf_undervolt_limit)))
    else $error("hf uv millivolts wrong");
  lf_ov_scale_a: assert property (!range_scaling_setting ##1 !range_scaling_setting |->
    lf_overvolt_mv == 13'h0C8 + 13'h005 * $past(ch3_lf_overvolt_limit))
    else $error("lf ov millivolts wrong");
  unconf_quiet_a: assert property (!channel_configured |->
    !hf_undervolt_fault && !hf_overvolt_fault) else $error("fault while unconfigured");
  // two sync flops plus one count edge: a low pin bars a rise three edges on,
  // and four edges on too when the code asks for more than one sample
  fault_stable_a: assert property (!hf_undervolt_raw |->
    ##3 !$rose(hf_undervolt_fault) ##1
    ($past(undervolt_debounce_code) == 4'h0 || !$rose(hf_undervolt_fault)))
    else $error("uv fault rose without a stable comparator");
  fault_release_a: assert property (!hf_overvolt_raw [*3] |=> !hf_overvolt_fault)
    else $error("ov fault held after comparator dropped");
endmodule
bind c3wtd_top c3wtd_sva #(.DEB_LONGEST_CYCLES(DEB_LONGEST_CYCLES)) c3wtd_sva_inst (
  .mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .hf_undervolt_raw,
  .hf_overvolt_raw, .range_scaling_setting, .ch3_hf_undervolt_limit, .ch3_lf_overvolt_limit,
  .hf_undervolt_mv, .lf_overvolt_mv, .overvolt_debounce_code, .undervolt_debounce_code,
  .channel_configured, .hf_undervolt_fault, .hf_overvolt_fault);

//--- verification/tb_ch3_window_threshold_debounce.sv
// bench for the channel 3 limit and debounce block
// assumes a shortened debounce scale of 1024 cycles for the longest code
module tb_ch3_window_threshold_debounce;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        range_scaling_setting = 1'b0;
  logic [12:0] rail_mv = 13'h3E8;
  logic [7:0]  lim [4] = '{8'h00, 8'hFF, 8'h55, 8'hAA};
  wire  [7:0]  reg_rdata;
  wire         uv_raw;
  wire         ov_raw;
  wire  [31:0] lims;
  wire  [51:0] mvs;
  wire  [3:0]  ov_code;
  wire  [3:0]  uv_code;
  wire         cfg;
  wire         uv_fault;
  wire         ov_fault;
  wire         irq;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cyc = 0;

  c3wtd_top #(.DEB_LONGEST_CYCLES(32'd1024)) c3wtd_top_inst (
    .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hf_undervolt_raw(uv_raw),
    .hf_overvolt_raw(ov_raw), .range_scaling_setting(range_scaling_setting),
    .ch3_hf_undervolt_limit(lims[7:0]), .ch3_hf_overvolt_limit(lims[15:8]),
    .ch3_lf_undervolt_limit(lims[23:16]), .ch3_lf_overvolt_limit(lims[31:24]),
    .hf_undervolt_mv(mvs[12:0]), .hf_overvolt_mv(mvs[25:13]), .lf_undervolt_mv(mvs[38:26]),
    .lf_overvolt_mv(mvs[51:39]), .overvolt_debounce_code(ov_code),
    .undervolt_debounce_code(uv_code), .channel_configured(cfg),
    .hf_undervolt_fault(uv_fault), .hf_overvolt_fault(ov_fault), .irq(irq));

  c3wtd_rail_model c3wtd_rail_model_inst (
    .rail_mv(rail_mv), .uv_mv(mvs[12:0]), .ov_mv(mvs[25:13]), .uv_raw(uv_raw), .ov_raw(ov_raw));

  always #4 mclk = ~mclk;

  task chk(input string what, input [15:0] seen, input [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task wr(input [7:0] a, input [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task rd(input [7:0] a, input [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("read data", reg_rdata, e);
  endtask

  task settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  // count edges from rail excursion to debounced fault
  task meas(input bit ov, input [3:0] c);
    int n;
    wr(8'h44, ov ? {c, 4'h0} : {4'h0, c});
    @(posedge mclk);
    rail_mv <= ov ? 13'hBB8 : 13'h000;
    n = 0;
    while (n < 1100 && (ov ? ov_fault : uv_fault) !== 1'b1) begin
      @(posedge mclk);
      #1 n++;
    end
    chk("debounce edges", n[15:0], (c > 4'h9 ? 16'd1024 : 16'd1 << c) + 16'd2);
    @(posedge mclk);
    rail_mv <= 13'h3E8;
    repeat (3) @(posedge mclk);
    #1 chk("fault release", ov ? ov_fault : uv_fault, 16'h0000);
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  initial begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 5; i++) rd(8'h40 + i[7:0], 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(8'h40 + i[7:0], lim[i]);
      rd(8'h40 + i[7:0], lim[i]);
      chk("limit port", lims[i*8 +: 8], lim[i]);
    end
    for (int s = 0; s < 2; s++) begin
      @(posedge mclk);
      range_scaling_setting <= s[0];
      settle();
      for (int i = 0; i < 4; i++)
        chk("millivolts", mvs[i*13 +: 13], s ? 800 + 20 * lim[i] : 200 + 5 * lim[i]);
    end
    @(posedge mclk);
    range_scaling_setting <= 1'b0;
    wr(8'h4A, 8'h01);
    rail_mv <= 13'h000;
    repeat (10) @(posedge mclk);
    #1 chk("unconfigured fault", uv_fault, 16'h0000);
    chk("configured early", cfg, 16'h0000);
    @(posedge mclk);
    rail_mv <= 13'h3E8;
    repeat (3) @(posedge mclk);
    for (int c = 0; c < 12; c++) meas(1'b0, c[3:0]);
    chk("configured", cfg, 16'h0001);
    chk("irq raised", irq, 16'h0001);
    meas(1'b1, 4'h3);
    meas(1'b1, 4'hF);
    chk("debounce fields", {ov_code, uv_code}, 16'h00F0);
    rd(8'h4B, 8'h04);
    rd(8'h48, 8'h07);
    wr(8'h4A, 8'h00);
    settle();
    chk("irq masked", irq, 16'h0000);
    wr(8'h4A, 8'h01);
    settle();
    chk("irq enabled", irq, 16'h0001);
    wr(8'h49, 8'h07);
    rd(8'h48, 8'h00);
    chk("irq cleared", irq, 16'h0000);
    rd(8'h49, 8'h00);
    rd(8'h50, 8'h00);
    wr(8'h48, 8'hFF);
    rd(8'h48, 8'h00);
    // a second reset must drop the channel back to unconfigured
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    settle();
    chk("configured after reset", cfg, 16'h0000);
    chk("limits after reset", lims[15:0], 16'h0000);
    chk("irq after reset", irq, 16'h0000);
    rd(8'h4B, 8'h00);
    end_sim();
  end
endmodule
